// >>> core/bamr_pkg.sv
package bamr_pkg;

   // ---------------------------------------------------------------
   // Command codes
   // ---------------------------------------------------------------
   localparam logic [7:0] CMD_LOW_CAP   = 8'h01;
   localparam logic [7:0] CMD_LOW_TIME  = 8'h02;
   localparam logic [7:0] CMD_MODE      = 8'h03;
   localparam logic [7:0] CMD_RATE      = 8'h04;

   // ---------------------------------------------------------------
   // Nonvolatile configuration locations
   // ---------------------------------------------------------------
   localparam logic [7:0] NV_LOW_TIME_ADDR = 8'h00;
   localparam logic [7:0] NV_LOW_CAP_ADDR  = 8'h02;

   // ---------------------------------------------------------------
   // Mode word fields
   // ---------------------------------------------------------------
   localparam int         BIT_RELEARN     = 7;
   localparam int         BIT_CHARGE_CTL  = 8;
   localparam int         BIT_PRIMARY     = 9;
   localparam int         BIT_ALARM_OFF   = 13;
   localparam int         BIT_CHARGER_OFF = 14;
   localparam int         BIT_CAP_UNITS   = 15;
   localparam logic [15:0] MODE_WR_MASK   = 16'he000;
   localparam logic [15:0] MODE_RESET     = 16'h0000;

   // ---------------------------------------------------------------
   // Alarm word flags
   // ---------------------------------------------------------------
   localparam int         ALM_BIT_LOW_CAP  = 9;
   localparam int         ALM_BIT_LOW_TIME = 8;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam longint     CLK_HZ           = 250000000;
   localparam longint     SUPPRESS_S       = 60;
   localparam longint     SUPPRESS_MIN_S   = 59;
   localparam longint     ALARM_GAP_S      = 10;
   localparam longint     SUPPRESS_CYCLES  = SUPPRESS_S * CLK_HZ;
   localparam longint     ALARM_GAP_CYCLES = ALARM_GAP_S * CLK_HZ;
   localparam int         RELEARN_CYCLE_LIMIT = 20;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  cmd;
      logic [15:0] wdata;
   } bamr_cmd_s;

   typedef struct packed {
      logic        send_host;
      logic        send_charger;
      logic [15:0] word;
   } bamr_alarm_s;

endpackage

// >>> core/bamr_down_timer.sv
`timescale 1ns/1ns
module bamr_down_timer
   import bamr_pkg::*;
#(
   parameter int W = 36
)(
   input  wire logic         ref_clk,
   input  wire logic         sys_rst,
   input  wire logic         load,
   input  wire logic [W-1:0] load_val,
   input  wire logic         clear,
   output      logic         running
);

   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      if (load) begin
         cnt_nxt = load_val;
      end else if (clear) begin
         cnt_nxt = '0;
      end else if (cnt_r != '0) begin
         cnt_nxt = cnt_r - W'(1);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign running = (cnt_r != '0);

endmodule

// >>> core/bamr_regs.sv
`timescale 1ns/1ns
module bamr_regs
   import bamr_pkg::*;
#(
   parameter longint SUPPRESS_CYC = SUPPRESS_CYCLES,
   parameter longint GAP_CYC      = ALARM_GAP_CYCLES,
   parameter int     TW           = 36
)(
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire bamr_cmd_s   cmd_in,
   output      logic [15:0] rdata,
   input  wire logic        nv_valid,
   input  wire logic [7:0]  nv_addr,
   input  wire logic [15:0] nv_data,
   input  wire logic [15:0] remaining_capacity_value,
   input  wire logic [15:0] averaged_time_to_empty,
   input  wire logic        cycle_count_inc,
   input  wire logic        full_capacity_update,
   input  wire logic        learn_done,
   input  wire logic        sleep_enter,
   input  wire logic        bus_idle,
   output      bamr_alarm_s alarm_message,
   output      logic        alarm_sent_ack,
   output      logic        may_master_bus,
   output      logic        charger_bcast_en,
   output      logic        cap_units_10mw,
   output      logic        recompute_now,
   output      logic        rate_refresh_pending
);

   // ---------------------------------------------------------------
   // Register state
   // ---------------------------------------------------------------
   logic [15:0] low_cap_r,   low_cap_nxt;
   logic [15:0] low_time_r,  low_time_nxt;
   logic [15:0] mode_r,      mode_nxt;
   logic [4:0]  cyc_cnt_r,   cyc_cnt_nxt;
   logic        cap_loaded_r, cap_loaded_nxt;
   logic        time_loaded_r, time_loaded_nxt;
   logic        rate_pend_r, rate_pend_nxt;
   logic        recomp_r,    recomp_nxt;
   logic [15:0] rdata_nxt;
   logic        suppress_run;
   logic        gap_run;
   logic        mode_cmd;
   logic        low_cap_flag;
   logic        low_time_flag;
   logic        alarm_any;
   logic        send_now;
   bamr_alarm_s alarm_r, alarm_nxt;

   // True when the bus carries a write of the given command code.
   function automatic logic cmd_write(input bamr_cmd_s c, input logic [7:0] code);
      return c.wr && (c.cmd == code);
   endfunction

   assign mode_cmd = cmd_write(cmd_in, CMD_MODE);

   // ---------------------------------------------------------------
   // Threshold comparison
   // ---------------------------------------------------------------
   // A zero threshold can never be exceeded from below, so it disables.
   assign low_cap_flag  = (low_cap_r != 16'h0000) &&
                          (remaining_capacity_value < low_cap_r);
   assign low_time_flag = (low_time_r != 16'h0000) &&
                          (averaged_time_to_empty < low_time_r);
   assign alarm_any = low_cap_flag || low_time_flag;

   // ---------------------------------------------------------------
   // Threshold and mode registers
   // ---------------------------------------------------------------
   always_comb begin
      low_cap_nxt     = low_cap_r;
      low_time_nxt    = low_time_r;
      cap_loaded_nxt  = cap_loaded_r;
      time_loaded_nxt = time_loaded_r;
      mode_nxt        = mode_r;
      cyc_cnt_nxt     = cyc_cnt_r;
      rate_pend_nxt   = rate_pend_r;
      recomp_nxt      = 1'b0;
      // Configuration loads only until the host takes ownership.
      if (nv_valid && nv_addr == NV_LOW_CAP_ADDR && !cap_loaded_r) begin
         low_cap_nxt = nv_data;
      end
      if (nv_valid && nv_addr == NV_LOW_TIME_ADDR && !time_loaded_r) begin
         low_time_nxt = nv_data;
      end
      if (cmd_write(cmd_in, CMD_LOW_CAP)) begin
         low_cap_nxt    = cmd_in.wdata;
         cap_loaded_nxt = 1'b1;
      end
      if (cmd_write(cmd_in, CMD_LOW_TIME)) begin
         low_time_nxt    = cmd_in.wdata;
         time_loaded_nxt = 1'b1;
      end
      if (mode_cmd) begin
         mode_nxt = (cmd_in.wdata & MODE_WR_MASK) | (mode_r & ~MODE_WR_MASK);
      end
      if (cmd_write(cmd_in, CMD_RATE)) begin
         rate_pend_nxt = 1'b0;
      end
      if (!suppress_run && mode_r[BIT_ALARM_OFF] && !mode_cmd) begin
         mode_nxt[BIT_ALARM_OFF] = 1'b0;
      end
      if (sleep_enter) begin
         mode_nxt[BIT_ALARM_OFF]   = 1'b0;
         mode_nxt[BIT_CHARGER_OFF] = 1'b0;
         mode_nxt[BIT_CAP_UNITS]   = 1'b0;
      end
      if (full_capacity_update) begin
         cyc_cnt_nxt = '0;
      end else if (cycle_count_inc && cyc_cnt_r != 5'(RELEARN_CYCLE_LIMIT)) begin
         cyc_cnt_nxt = cyc_cnt_r + 5'd1;
      end
      // Setting wins over clearing when both arrive together.
      if (learn_done) begin
         mode_nxt[BIT_RELEARN] = 1'b0;
      end
      if (cyc_cnt_nxt == 5'(RELEARN_CYCLE_LIMIT) && cyc_cnt_r != 5'(RELEARN_CYCLE_LIMIT)) begin
         mode_nxt[BIT_RELEARN] = 1'b1;
      end
      mode_nxt[6:0]           = 7'h00;
      mode_nxt[12:10]         = 3'h0;
      mode_nxt[BIT_CHARGE_CTL] = 1'b0;
      mode_nxt[BIT_PRIMARY]    = 1'b0;
      // A units change by write or by sleep entry both trigger a recompute.
      if (mode_nxt[BIT_CAP_UNITS] != mode_r[BIT_CAP_UNITS]) begin
         recomp_nxt    = 1'b1;
         rate_pend_nxt = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         low_cap_r     <= 16'h0000;
         low_time_r    <= 16'h0000;
         cap_loaded_r  <= 1'b0;
         time_loaded_r <= 1'b0;
         mode_r        <= MODE_RESET | (16'h0001 << BIT_RELEARN);
         cyc_cnt_r     <= 5'd0;
         rate_pend_r   <= 1'b0;
         recomp_r      <= 1'b0;
      end else begin
         low_cap_r     <= low_cap_nxt;
         low_time_r    <= low_time_nxt;
         cap_loaded_r  <= cap_loaded_nxt;
         time_loaded_r <= time_loaded_nxt;
         mode_r        <= mode_nxt;
         cyc_cnt_r     <= cyc_cnt_nxt;
         rate_pend_r   <= rate_pend_nxt;
         recomp_r      <= recomp_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Suppression and spacing timers
   // ---------------------------------------------------------------
   bamr_down_timer #(.W(TW)) u_suppress (
      .ref_clk  (ref_clk),
      .sys_rst  (sys_rst),
      .load     (mode_cmd && cmd_in.wdata[BIT_ALARM_OFF]),
      .load_val (TW'(SUPPRESS_CYC - 1)),
      .clear    (sleep_enter),
      .running  (suppress_run)
   );

   bamr_down_timer #(.W(TW)) u_gap (
      .ref_clk  (ref_clk),
      .sys_rst  (sys_rst),
      .load     (send_now),
      .load_val (TW'(GAP_CYC)),
      .clear    (1'b0),
      .running  (gap_run)
   );

   // ---------------------------------------------------------------
   // Alarm message generation
   // ---------------------------------------------------------------
   assign may_master_bus = !mode_r[BIT_ALARM_OFF];
   assign send_now = alarm_any && may_master_bus && !gap_run && bus_idle;

   always_comb begin
      alarm_nxt = '0;
      if (send_now) begin
         alarm_nxt.send_host    = 1'b1;
         alarm_nxt.send_charger = 1'b1;
         alarm_nxt.word[ALM_BIT_LOW_CAP]  = low_cap_flag;
         alarm_nxt.word[ALM_BIT_LOW_TIME] = low_time_flag;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         alarm_r <= '0;
      end else begin
         alarm_r <= alarm_nxt;
      end
   end

   assign alarm_message  = alarm_r;
   assign alarm_sent_ack = alarm_r.send_host;

   // ---------------------------------------------------------------
   // Mode outputs and read port
   // ---------------------------------------------------------------
   assign charger_bcast_en     = !mode_r[BIT_CHARGER_OFF];
   assign cap_units_10mw       = mode_r[BIT_CAP_UNITS];
   assign recompute_now        = recomp_r;
   assign rate_refresh_pending = rate_pend_r;

   always_comb begin
      rdata_nxt = 16'h0000;
      unique case (cmd_in.cmd)
         CMD_LOW_CAP:  rdata_nxt = low_cap_r;
         CMD_LOW_TIME: rdata_nxt = low_time_r;
         CMD_MODE:     rdata_nxt = mode_r;
         default:      rdata_nxt = 16'h0000;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rdata <= 16'h0000;
      end else if (cmd_in.rd) begin
         rdata <= rdata_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   sequence s_send;
      alarm_r.send_host;
   endsequence

   chk_cap_disable: assert property (@(posedge ref_clk) disable iff (sys_rst)
      s_send |-> !(alarm_r.word[ALM_BIT_LOW_CAP] && $past(low_cap_r) == 16'h0000))
      else $error("Low-capacity alarm sent with zero threshold.");
   chk_time_disable: assert property (@(posedge ref_clk) disable iff (sys_rst)
      s_send |-> !(alarm_r.word[ALM_BIT_LOW_TIME] && $past(low_time_r) == 16'h0000))
      else $error("Low-time alarm sent with zero threshold.");
   chk_cap_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
      s_send |-> alarm_r.word[ALM_BIT_LOW_CAP] ==
         ($past(remaining_capacity_value) < $past(low_cap_r) && $past(low_cap_r) != 16'h0000))
      else $error("Low-capacity flag does not match comparison.");
   chk_time_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
      s_send |-> alarm_r.word[ALM_BIT_LOW_TIME] ==
         ($past(averaged_time_to_empty) < $past(low_time_r) && $past(low_time_r) != 16'h0000))
      else $error("Low-time flag does not match comparison.");
   chk_mode_low_bits: assert property (@(posedge ref_clk) disable iff (sys_rst)
      mode_r[6:0] == 7'h00 && !mode_r[BIT_CHARGE_CTL] && !mode_r[BIT_PRIMARY])
      else $error("Mode word forced-zero bits are set.");
   chk_forced_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
      mode_cmd |=> !mode_r[BIT_CHARGE_CTL] && !mode_r[BIT_PRIMARY])
      else $error("Unused mode bits took a written value.");
   chk_no_send_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
      mode_r[BIT_ALARM_OFF] |=> !alarm_r.send_host)
      else $error("Alarm sent while broadcasts disabled.");
   chk_both_dest: assert property (@(posedge ref_clk) disable iff (sys_rst)
      alarm_r.send_host |-> alarm_r.send_charger)
      else $error("Alarm not sent to both host and charger.");
   chk_gap_spacing: assert property (@(posedge ref_clk) disable iff (sys_rst)
      s_send |=> !alarm_r.send_host [*8])
      else $error("Alarm messages too close together.");
   chk_sleep_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
      sleep_enter |=> mode_r[15:13] == 3'b000)
      else $error("Sleep entry did not clear mode bits.");
   chk_relearn_clr: assert property (@(posedge ref_clk) disable iff (sys_rst)
      learn_done && !(cycle_count_inc && cyc_cnt_r == 5'(RELEARN_CYCLE_LIMIT - 1)) &&
      !full_capacity_update |=> !mode_r[BIT_RELEARN] || $past(cyc_cnt_r) == 5'(RELEARN_CYCLE_LIMIT - 1))
      else $error("Relearn flag not cleared after learning.");
   chk_units_out: assert property (@(posedge ref_clk) disable iff (sys_rst)
      mode_cmd && !sleep_enter |=> cap_units_10mw == $past(cmd_in.wdata[BIT_CAP_UNITS]))
      else $error("Units output does not follow the written bit.");
   chk_units_recomp: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $changed(mode_r[BIT_CAP_UNITS]) |-> recomp_r)
      else $error("Units bit changed without a recompute pulse.");
   chk_alarm_expiry: assert property (@(posedge ref_clk) disable iff (sys_rst)
      mode_r[BIT_ALARM_OFF] && !suppress_run && !mode_cmd |=> !mode_r[BIT_ALARM_OFF])
      else $error("Alarm-off bit outlived its suppression timer.");
   chk_send_allowed: assert property (@(posedge ref_clk) disable iff (sys_rst)
      s_send |-> $past(bus_idle) && $past(may_master_bus))
      else $error("Alarm sent while bus busy or mastering barred.");

endmodule

// >>> verification/bamr_far_model.sv
`timescale 1ns/1ns
module bamr_far_model
   import bamr_pkg::*;
#(
   parameter logic [15:0] NV_CAP  = 16'h0123,
   parameter logic [15:0] NV_TIME = 16'h0045
)(
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire logic        stall,
   input  wire logic        reload,
   input  wire bamr_alarm_s alarm_message,
   input  wire logic        alarm_sent_ack,
   output      logic        bus_idle,
   output      logic        nv_valid,
   output      logic [7:0]  nv_addr,
   output      logic [15:0] nv_data,
   output      logic [15:0] alarm_cnt,
   output      logic [15:0] last_word,
   output      logic [31:0] min_gap,
   output      logic        pair_err
);
   logic [3:0]  seq_r;
   logic [31:0] gap_r;

   // ---------------------------------------------------------------
   // Config delivery, bus occupancy and alarm reception.
   // ---------------------------------------------------------------
   // Outside a delivery the config lines toggle so stale data never looks valid.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         seq_r     <= 4'h0;
         nv_valid  <= 1'b0;
         nv_addr   <= 8'h5a;
         nv_data   <= 16'ha5a5;
         bus_idle  <= 1'b1;
         alarm_cnt <= 16'h0000;
         last_word <= 16'h0000;
         min_gap   <= 32'hffffffff;
         gap_r     <= 32'h0;
         pair_err  <= 1'b0;
      end else begin
         seq_r    <= reload ? 4'h0 : (seq_r == 4'hf ? seq_r : seq_r + 4'h1);
         nv_valid <= (seq_r == 4'h1) || (seq_r == 4'h3);
         nv_addr  <= (seq_r == 4'h1) ? NV_LOW_TIME_ADDR : (seq_r == 4'h3) ? NV_LOW_CAP_ADDR : ~nv_addr;
         nv_data  <= (seq_r == 4'h1) ? NV_TIME : (seq_r == 4'h3) ? NV_CAP : ~nv_data;
         bus_idle <= ~stall;
         gap_r    <= (gap_r == 32'hffffffff) ? gap_r : gap_r + 32'h1;
         if (alarm_message.send_host !== alarm_message.send_charger || alarm_sent_ack !== alarm_message.send_host) begin
            pair_err <= 1'b1;
         end
         if (alarm_message.send_host === 1'b1) begin
            alarm_cnt <= alarm_cnt + 16'h1;
            last_word <= alarm_message.word;
            gap_r     <= 32'h0;
            if (alarm_cnt != 16'h0 && gap_r + 32'h1 < min_gap) begin
               min_gap <= gap_r + 32'h1;
            end
         end
      end
   end
endmodule

// >>> verification/battery_alarm_mode_regs_tb.sv
`timescale 1ns/1ns
module battery_alarm_mode_regs_tb;
   import bamr_pkg::*;
   localparam longint SUP = 200;
   localparam longint GAP = 20;
   logic        ref_clk;
   logic        sys_rst;
   bamr_cmd_s   cmd_in;
   logic [15:0] rdata;
   logic        nv_valid;
   logic [7:0]  nv_addr;
   logic [15:0] nv_data;
   logic [15:0] cap;
   logic [15:0] tte;
   logic [4:0]  ev;
   logic        stall;
   logic        bus_idle;
   bamr_alarm_s alarm_message;
   logic        ack;
   logic        may_master_bus;
   logic        charger_bcast_en;
   logic        cap_units_10mw;
   logic        recompute_now;
   logic        rate_refresh_pending;
   logic [15:0] alarm_cnt;
   logic [15:0] last_word;
   logic [31:0] min_gap;
   logic        pair_err;
   logic [15:0] rc_cnt;
   logic [15:0] snap;
   int          err_count;
   int          n_tests;

   bamr_regs #(.SUPPRESS_CYC(SUP), .GAP_CYC(GAP)) DUT (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_in(cmd_in), .rdata(rdata), .nv_valid(nv_valid),
      .nv_addr(nv_addr), .nv_data(nv_data), .remaining_capacity_value(cap), .averaged_time_to_empty(tte),
      .cycle_count_inc(ev[4]), .full_capacity_update(ev[3]), .learn_done(ev[2]), .sleep_enter(ev[1]),
      .bus_idle(bus_idle), .alarm_message(alarm_message), .alarm_sent_ack(ack), .may_master_bus(may_master_bus),
      .charger_bcast_en(charger_bcast_en), .cap_units_10mw(cap_units_10mw), .recompute_now(recompute_now),
      .rate_refresh_pending(rate_refresh_pending));

   bamr_far_model FAR (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .stall(stall), .reload(ev[0]), .alarm_message(alarm_message),
      .alarm_sent_ack(ack), .bus_idle(bus_idle), .nv_valid(nv_valid), .nv_addr(nv_addr), .nv_data(nv_data),
      .alarm_cnt(alarm_cnt), .last_word(last_word), .min_gap(min_gap), .pair_err(pair_err));

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      rc_cnt <= sys_rst ? 16'h0 : rc_cnt + {15'h0, recompute_now === 1'b1};
   end

   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic chkb(input string what, input logic got, input logic exp);
      chk(what, {15'h0, got}, {15'h0, exp});
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      @(posedge ref_clk);
      cmd_in <= '{wr: 1'b1, rd: 1'b0, cmd: c, wdata: d};
      @(posedge ref_clk);
      cmd_in <= '0;
   endtask

   task automatic rd(input logic [7:0] c, input logic [15:0] exp, input string what);
      @(posedge ref_clk);
      cmd_in <= '{wr: 1'b0, rd: 1'b1, cmd: c, wdata: 16'h0};
      @(posedge ref_clk);
      cmd_in <= '0;
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk(what, rdata, exp);
   endtask

   task automatic pulse(input logic [4:0] m);
      @(posedge ref_clk);
      ev <= m;
      @(posedge ref_clk);
      ev <= 5'h00;
   endtask

   task automatic setq(input logic [15:0] c, input logic [15:0] t);
      @(posedge ref_clk);
      cap <= c;
      tte <= t;
      cyc(3);
      snap = alarm_cnt;
   endtask

   initial begin
      #80000;
      err_count++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      final_report();
   end

   initial begin
      sys_rst = 1'b1;
      cmd_in = '0;
      cap = 16'hffff;
      tte = 16'hffff;
      ev = 5'h00;
      stall = 1'b0;
      err_count = 0;
      n_tests = 0;
      cyc(20);
      sys_rst <= 1'b0;
      cyc(8);
      rd(CMD_MODE, 16'h0080, "mode after reset");
      rd(CMD_LOW_CAP, 16'h0123, "cap threshold from config");
      rd(CMD_LOW_TIME, 16'h0045, "time threshold from config");
      rd(8'h07, 16'h0000, "unmapped read");
      wr(CMD_LOW_CAP, 16'hffff);
      rd(CMD_LOW_CAP, 16'hffff, "cap threshold full range");
      pulse(5'h01);
      cyc(8);
      rd(CMD_LOW_CAP, 16'hffff, "cap threshold kept after config");
      wr(CMD_MODE, 16'hffff);
      rd(CMD_MODE, 16'he080, "mode write mask");
      chkb("units bit", cap_units_10mw, 1'b1);
      chkb("charger off", charger_bcast_en, 1'b0);
      chkb("no mastering", may_master_bus, 1'b0);
      chk("recompute pulses", rc_cnt, 16'h1);
      chkb("rate refresh pending", rate_refresh_pending, 1'b1);
      wr(CMD_RATE, 16'h0001);
      cyc(2);
      chkb("rate refresh done", rate_refresh_pending, 1'b0);
      wr(CMD_MODE, 16'h4000);
      cyc(2);
      chkb("alarm bit independent", may_master_bus, 1'b1);
      chkb("charger bit alone", charger_bcast_en, 1'b0);
      chk("recompute on clear", rc_cnt, 16'h2);
      wr(CMD_MODE, 16'he000);
      pulse(5'h02);
      rd(CMD_MODE, 16'h0080, "mode after sleep");
      chkb("sleep master", may_master_bus, 1'b1);
      chkb("sleep charger", charger_bcast_en, 1'b1);
      chkb("sleep units", cap_units_10mw, 1'b0);
      chk("recompute on sleep", rc_cnt, 16'h4);
      pulse(5'h04);
      rd(CMD_MODE, 16'h0000, "relearn cleared");
      repeat (19) pulse(5'h10);
      pulse(5'h08);
      repeat (19) pulse(5'h10);
      rd(CMD_MODE, 16'h0000, "count restarted");
      pulse(5'h10);
      rd(CMD_MODE, 16'h0080, "relearn after twenty");
      wr(CMD_LOW_CAP, 16'h0100);
      setq(16'h00ff, 16'hffff);
      cyc(5 * GAP);
      chkb("capacity alarms sent", alarm_cnt >= snap + 16'd4, 1'b1);
      chk("capacity flag", last_word & 16'h0300, 16'h0200);
      chkb("alarm spacing", min_gap >= GAP, 1'b1);
      chkb("host and charger", pair_err, 1'b0);
      stall <= 1'b1;
      setq(16'h00ff, 16'hffff);
      cyc(3 * GAP);
      chk("held while bus busy", alarm_cnt, snap);
      stall <= 1'b0;
      cyc(GAP + 4);
      chkb("sent once bus idle", alarm_cnt > snap, 1'b1);
      setq(16'h0100, 16'hffff);
      cyc(3 * GAP);
      chk("recovered stops", alarm_cnt, snap);
      wr(CMD_LOW_CAP, 16'h0000);
      setq(16'h0000, 16'hffff);
      cyc(3 * GAP);
      chk("zero cap threshold", alarm_cnt, snap);
      wr(CMD_LOW_TIME, 16'h0050);
      setq(16'h0000, 16'h004f);
      cyc(2 * GAP);
      chkb("time alarms sent", alarm_cnt > snap, 1'b1);
      chk("time flag", last_word & 16'h0300, 16'h0100);
      setq(16'h0000, 16'h0050);
      cyc(3 * GAP);
      chk("time recovered", alarm_cnt, snap);
      wr(CMD_LOW_TIME, 16'h0000);
      setq(16'h0000, 16'h0000);
      cyc(3 * GAP);
      chk("zero time threshold", alarm_cnt, snap);
      wr(CMD_LOW_TIME, 16'h0050);
      wr(CMD_MODE, 16'h2000);
      setq(16'h0000, 16'h0010);
      cyc(147);
      wr(CMD_MODE, 16'h2000);
      cyc(150);
      chk("suppressed past restart", alarm_cnt, snap);
      cyc(47);
      chkb("still suppressed", may_master_bus, 1'b0);
      cyc(4);
      chkb("suppression expired", may_master_bus, 1'b1);
      rd(CMD_MODE, 16'h0080, "alarm bit self cleared");
      cyc(4);
      chkb("alarms resumed", alarm_cnt > snap, 1'b1);
      final_report();
   end
endmodule
